/* rtl/cabx_pkg.sv */
// package of the alu and branch execution block: operation codes, flag positions,
// cycle counts and reset values.
// assumes one core clock and a caller that issues one operation at a time.
package cabx_pkg;

   // ---------------------------------------------------------------
   // operations
   // ---------------------------------------------------------------
   typedef enum logic [5:0] {
      OP_ADD_REGS, OP_ADD_WITH_CARRY, OP_WORD_ADD_IMMEDIATE,
      OP_SUB_REGS, OP_SUB_IMMEDIATE, OP_SUB_WITH_CARRY, OP_SUB_IMMEDIATE_WITH_CARRY,
      OP_WORD_SUB_IMMEDIATE,
      OP_AND_REGS, OP_AND_IMMEDIATE, OP_OR_REGS, OP_OR_IMMEDIATE, OP_EXCLUSIVE_OR_REGS,
      OP_ONES_COMPLEMENT, OP_TWOS_COMPLEMENT, OP_SET_BITS_MASK, OP_CLEAR_BITS_MASK,
      OP_INCREMENT, OP_DECREMENT, OP_TEST_ZERO_MINUS, OP_CLEAR_REG, OP_SET_ALL_ONES,
      OP_RELATIVE_JUMP, OP_POINTER_JUMP, OP_RELATIVE_CALL, OP_POINTER_CALL,
      OP_SUB_RETURN, OP_INTERRUPT_RETURN,
      OP_COMPARE_SKIP_EQUAL, OP_COMPARE_REGS, OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE,
      OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET,
      OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR, OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT,
      OP_BRANCH_UNSIGNED_GE, OP_BRANCH_UNSIGNED_LT, OP_BRANCH_HALFCARRY_SET,
      OP_BRANCH_HALFCARRY_CLEAR, OP_BRANCH_IRQ_ENABLED, OP_BRANCH_IRQ_DISABLED,
      OP_BRANCH_OVERFLOW_SET, OP_BRANCH_OVERFLOW_CLEAR, OP_BRANCH_BITSTORE_SET,
      OP_BRANCH_BITSTORE_CLEAR
   } cabx_op_t;

   // ---------------------------------------------------------------
   // status flag bit positions
   // ---------------------------------------------------------------
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;

   // ---------------------------------------------------------------
   // cycle counts, reset values, register indices
   // ---------------------------------------------------------------
   localparam logic [2:0] CYC_ONE   = 3'h1;
   localparam logic [2:0] CYC_TWO   = 3'h2;
   localparam logic [2:0] CYC_THREE = 3'h3;
   localparam logic [2:0] CYC_FOUR  = 3'h4;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [7:0] REG_RST   = 8'h00;
   localparam logic [4:0] PTR_LO    = 5'h1e;
   localparam logic [4:0] PTR_HI    = 5'h1f;
   localparam logic [1:0] SKIP_SHORT_STEP = 2'h2;
   localparam logic [1:0] SKIP_LONG_STEP  = 2'h3;

endpackage : cabx_pkg

/* rtl/cabx_exec.sv */
// execution unit for arithmetic, logic, compare, skip and branch operations.
// holds the 32 working registers, the status flags, the program counter and a
// small return stack. assumes the caller presents one operation per START pulse
// while BUSY is low, and the io byte comes from logic on the same clock.
`timescale 1ns/1ns

module cabx_exec
   import cabx_pkg::*;
#(
   parameter int PCW       = 16,
   parameter int STK_DEPTH = 16
)(
   input  wire logic              CLK,
   input  wire logic              RST_N,
   input  wire logic              START,
   input  wire cabx_pkg::cabx_op_t OP,
   input  wire logic [4:0]        RD,
   input  wire logic [4:0]        RR,
   input  wire logic [7:0]        K,
   input  wire logic [2:0]        BIT_SEL,
   input  wire logic [11:0]       OFFSET,
   input  wire logic [7:0]        IO_VALUE,
   input  wire logic              SKIP_LONG,
   input  wire logic              RF_WE,
   input  wire logic [4:0]        RF_WADDR,
   input  wire logic [7:0]        RF_WDATA,
   input  wire logic [4:0]        RF_RADDR,
   output logic [7:0]             RF_RDATA,
   output logic [PCW-1:0]         PC,
   output logic [7:0]             FLAGS,
   output logic                   BUSY,
   output logic                   DONE
);
   import cabx_pkg::*;

   localparam int SPW = $clog2(STK_DEPTH);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [7:0]     rf_r [0:31];
   logic [PCW-1:0] stk_r [0:STK_DEPTH-1];
   logic [PCW-1:0] pc_r, pc_nxt;
   logic [7:0]     flags_r, flags_nxt;
   logic [SPW-1:0] sp_r, sp_nxt;
   logic [2:0]     wait_r, wait_nxt;
   logic           busy_r, busy_nxt;
   logic           done_r, done_nxt;
   logic [7:0]     rdata_r;

   logic           we_lo, we_hi, push;
   logic [4:0]     wa_lo, wa_hi;
   logic [7:0]     wd_lo, wd_hi;
   logic [PCW-1:0] push_val;

   // ---------------------------------------------------------------
   // operand paths
   // ---------------------------------------------------------------
   logic           take, imm_op, carry_op, cond;
   logic [7:0]     a, b, res, sa, sb;
   logic [8:0]     sum9, dif9;
   logic [4:0]     rd_hi;
   logic [15:0]    w_in, w_res;
   logic [PCW-1:0] pc_inc, pc_rel, pc_skip;
   logic [2:0]     cyc;

   assign take   = START & ~busy_r;
   assign rd_hi  = RD | 5'h01;
   assign w_in   = {rf_r[rd_hi], rf_r[RD & 5'h1e]};
   assign pc_inc = pc_r + PCW'(1);
   assign pc_rel = pc_r + PCW'($signed(OFFSET)) + PCW'(1);
   assign pc_skip = pc_r + PCW'(SKIP_LONG ? SKIP_LONG_STEP : SKIP_SHORT_STEP);

   // operand selection for the byte arithmetic paths
   always_comb
   begin
      imm_op   = (OP == OP_SUB_IMMEDIATE) || (OP == OP_SUB_IMMEDIATE_WITH_CARRY) ||
                 (OP == OP_AND_IMMEDIATE) || (OP == OP_OR_IMMEDIATE) ||
                 (OP == OP_COMPARE_IMMEDIATE) || (OP == OP_SET_BITS_MASK) ||
                 (OP == OP_CLEAR_BITS_MASK);
      carry_op = (OP == OP_ADD_WITH_CARRY) || (OP == OP_SUB_WITH_CARRY) ||
                 (OP == OP_SUB_IMMEDIATE_WITH_CARRY) || (OP == OP_COMPARE_WITH_CARRY);
      a  = rf_r[RD];
      b  = imm_op ? K : rf_r[RR];
      // twos complement runs through the subtractor as zero minus the register
      sa = (OP == OP_TWOS_COMPLEMENT) ? 8'h00 : a;
      sb = (OP == OP_TWOS_COMPLEMENT) ? a : b;
      sum9 = {1'b0, a} + {1'b0, b} + {8'h00, carry_op & flags_r[FLAG_C]};
      dif9 = {1'b0, sa} - {1'b0, sb} - {8'h00, carry_op & flags_r[FLAG_C]};
      if (OP == OP_WORD_SUB_IMMEDIATE)
         w_res = w_in - {10'h000, K[5:0]};
      else
         w_res = w_in + {10'h000, K[5:0]};
   end

   // ---------------------------------------------------------------
   // execution: next pc, flags, register writes, stack
   // ---------------------------------------------------------------
   always_comb
   begin
      pc_nxt    = pc_r;
      flags_nxt = flags_r;
      sp_nxt    = sp_r;
      we_lo     = 1'b0;
      we_hi     = 1'b0;
      wa_lo     = RD;
      wa_hi     = rd_hi;
      wd_lo     = 8'h00;
      wd_hi     = w_res[15:8];
      push      = 1'b0;
      push_val  = pc_inc;
      res       = 8'h00;
      cond      = 1'b0;
      cyc       = CYC_ONE;
      if (take)
      begin
         pc_nxt = pc_inc;
         unique case (OP)
            OP_ADD_REGS, OP_ADD_WITH_CARRY:
            begin
               res = sum9[7:0];
               we_lo = 1'b1;
               flags_nxt[FLAG_C] = sum9[8];
               flags_nxt[FLAG_H] = (a[3] & b[3]) | (b[3] & ~res[3]) | (~res[3] & a[3]);
               flags_nxt[FLAG_V] = (a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]);
               flags_nxt[FLAG_N] = res[7];
               flags_nxt[FLAG_Z] = (res == 8'h00);
            end
            OP_SUB_REGS, OP_SUB_IMMEDIATE, OP_SUB_WITH_CARRY, OP_SUB_IMMEDIATE_WITH_CARRY,
            OP_COMPARE_REGS, OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE, OP_TWOS_COMPLEMENT:
            begin
               res = dif9[7:0];
               // compares keep the destination untouched
               we_lo = (OP != OP_COMPARE_REGS) && (OP != OP_COMPARE_WITH_CARRY) &&
                       (OP != OP_COMPARE_IMMEDIATE);
               flags_nxt[FLAG_C] = dif9[8];
               flags_nxt[FLAG_H] = (~sa[3] & sb[3]) | (sb[3] & res[3]) | (res[3] & ~sa[3]);
               flags_nxt[FLAG_V] = (sa[7] & ~sb[7] & ~res[7]) | (~sa[7] & sb[7] & res[7]);
               flags_nxt[FLAG_N] = res[7];
               // with-carry forms chain zero over multi-byte values
               flags_nxt[FLAG_Z] = (res == 8'h00) & (~carry_op | flags_r[FLAG_Z]);
            end
            OP_AND_REGS, OP_AND_IMMEDIATE, OP_OR_REGS, OP_OR_IMMEDIATE, OP_EXCLUSIVE_OR_REGS,
            OP_SET_BITS_MASK, OP_CLEAR_BITS_MASK, OP_TEST_ZERO_MINUS, OP_CLEAR_REG:
            begin
               unique case (OP)
                  OP_AND_REGS, OP_AND_IMMEDIATE: res = a & b;
                  OP_OR_REGS, OP_OR_IMMEDIATE:   res = a | b;
                  OP_EXCLUSIVE_OR_REGS:          res = a ^ b;
                  OP_SET_BITS_MASK:              res = a | K;
                  OP_CLEAR_BITS_MASK:            res = a & ~K;
                  OP_TEST_ZERO_MINUS:            res = a & a;
                  default:                       res = 8'h00;
               endcase
               we_lo = (OP != OP_TEST_ZERO_MINUS);
               flags_nxt[FLAG_V] = 1'b0;
               flags_nxt[FLAG_N] = res[7];
               flags_nxt[FLAG_Z] = (res == 8'h00);
            end
            OP_ONES_COMPLEMENT:
            begin
               res = 8'hff - a;
               we_lo = 1'b1;
               flags_nxt[FLAG_C] = 1'b1;
               flags_nxt[FLAG_V] = 1'b0;
               flags_nxt[FLAG_N] = res[7];
               flags_nxt[FLAG_Z] = (res == 8'h00);
            end
            OP_INCREMENT, OP_DECREMENT:
            begin
               res = (OP == OP_INCREMENT) ? a + 8'h01 : a - 8'h01;
               we_lo = 1'b1;
               flags_nxt[FLAG_V] = (OP == OP_INCREMENT) ? (res == 8'h80) : (res == 8'h7f);
               flags_nxt[FLAG_N] = res[7];
               flags_nxt[FLAG_Z] = (res == 8'h00);
            end
            OP_SET_ALL_ONES:
            begin
               res = 8'hff;
               we_lo = 1'b1;
            end
            OP_WORD_ADD_IMMEDIATE, OP_WORD_SUB_IMMEDIATE:
            begin
               cyc   = CYC_TWO;
               wa_lo = RD & 5'h1e;
               res   = w_res[7:0];
               we_lo = 1'b1;
               we_hi = 1'b1;
               if (OP == OP_WORD_ADD_IMMEDIATE)
               begin
                  flags_nxt[FLAG_C] = ~w_res[15] & w_in[15];
                  flags_nxt[FLAG_V] = ~w_in[15] & w_res[15];
               end
               else
               begin
                  flags_nxt[FLAG_C] = w_res[15] & ~w_in[15];
                  flags_nxt[FLAG_V] = w_in[15] & ~w_res[15];
               end
               flags_nxt[FLAG_N] = w_res[15];
               flags_nxt[FLAG_Z] = (w_res == 16'h0000);
               flags_nxt[FLAG_S] = w_res[15] ^ flags_nxt[FLAG_V];
            end
            OP_RELATIVE_JUMP, OP_RELATIVE_CALL:
            begin
               pc_nxt = pc_rel;
               push   = (OP == OP_RELATIVE_CALL);
               cyc    = push ? CYC_THREE : CYC_TWO;
            end
            OP_POINTER_JUMP, OP_POINTER_CALL:
            begin
               pc_nxt = PCW'({rf_r[PTR_HI], rf_r[PTR_LO]});
               push   = (OP == OP_POINTER_CALL);
               cyc    = push ? CYC_THREE : CYC_TWO;
            end
            OP_SUB_RETURN, OP_INTERRUPT_RETURN:
            begin
               sp_nxt = sp_r - SPW'(1);
               pc_nxt = stk_r[sp_nxt];
               cyc    = CYC_FOUR;
               if (OP == OP_INTERRUPT_RETURN)
                  flags_nxt[FLAG_I] = 1'b1;
            end
            OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
            OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET:
            begin
               unique case (OP)
                  OP_COMPARE_SKIP_EQUAL: cond = (a == rf_r[RR]);
                  OP_SKIP_REG_BIT_CLEAR: cond = ~rf_r[RR][BIT_SEL];
                  OP_SKIP_REG_BIT_SET:   cond = rf_r[RR][BIT_SEL];
                  OP_SKIP_IO_BIT_CLEAR:  cond = ~IO_VALUE[BIT_SEL];
                  default:               cond = IO_VALUE[BIT_SEL];
               endcase
               if (cond)
               begin
                  pc_nxt = pc_skip;
                  cyc    = CYC_TWO;
               end
            end
            default:
            begin
               // conditional relative branches
               unique case (OP)
                  OP_BRANCH_FLAG_SET:        cond = flags_r[BIT_SEL];
                  OP_BRANCH_FLAG_CLEAR:      cond = ~flags_r[BIT_SEL];
                  OP_BRANCH_SIGNED_GE:       cond = ~(flags_r[FLAG_N] ^ flags_r[FLAG_V]);
                  OP_BRANCH_SIGNED_LT:       cond = flags_r[FLAG_N] ^ flags_r[FLAG_V];
                  OP_BRANCH_UNSIGNED_GE:     cond = ~flags_r[FLAG_C];
                  OP_BRANCH_UNSIGNED_LT:     cond = flags_r[FLAG_C];
                  OP_BRANCH_HALFCARRY_SET:   cond = flags_r[FLAG_H];
                  OP_BRANCH_HALFCARRY_CLEAR: cond = ~flags_r[FLAG_H];
                  OP_BRANCH_IRQ_ENABLED:     cond = flags_r[FLAG_I];
                  OP_BRANCH_IRQ_DISABLED:    cond = ~flags_r[FLAG_I];
                  OP_BRANCH_OVERFLOW_SET:    cond = flags_r[FLAG_V];
                  OP_BRANCH_OVERFLOW_CLEAR:  cond = ~flags_r[FLAG_V];
                  OP_BRANCH_BITSTORE_SET:    cond = flags_r[FLAG_T];
                  OP_BRANCH_BITSTORE_CLEAR:  cond = ~flags_r[FLAG_T];
                  default:                   cond = 1'b0;
               endcase
               if (cond)
               begin
                  pc_nxt = pc_rel;
                  cyc    = CYC_TWO;
               end
            end
         endcase
         wd_lo = res;
         if (push)
            sp_nxt = sp_r + SPW'(1);
      end
   end

   // busy and done sequencing from the cycle count of the operation taken
   always_comb
   begin
      wait_nxt = wait_r;
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      if (take)
      begin
         wait_nxt = cyc - CYC_ONE;
         busy_nxt = (cyc != CYC_ONE);
         done_nxt = (cyc == CYC_ONE);
      end
      else if (busy_r)
      begin
         wait_nxt = wait_r - CYC_ONE;
         if (wait_r == CYC_ONE)
         begin
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         for (int i = 0; i < 32; i++)
            rf_r[i] <= REG_RST;
         for (int j = 0; j < STK_DEPTH; j++)
            stk_r[j] <= '0;
         pc_r    <= '0;
         flags_r <= FLAGS_RST;
         sp_r    <= '0;
         wait_r  <= 3'h0;
         busy_r  <= 1'b0;
         done_r  <= 1'b0;
         rdata_r <= 8'h00;
      end
      else
      begin
         // an executing write wins over the loader port on the same register
         if (RF_WE)
            rf_r[RF_WADDR] <= RF_WDATA;
         if (we_lo)
            rf_r[wa_lo] <= wd_lo;
         if (we_hi)
            rf_r[wa_hi] <= wd_hi;
         if (push)
            stk_r[sp_r] <= push_val;
         pc_r    <= pc_nxt;
         flags_r <= flags_nxt;
         sp_r    <= sp_nxt;
         wait_r  <= wait_nxt;
         busy_r  <= busy_nxt;
         done_r  <= done_nxt;
         rdata_r <= rf_r[RF_RADDR];
      end
   end

   assign RF_RDATA = rdata_r;
   assign PC       = pc_r;
   assign FLAGS    = flags_r;
   assign BUSY     = busy_r;
   assign DONE     = done_r;

endmodule // cabx_exec

/* sim/cabx_exec_checker.sv */
// assertion checker for the alu and branch execution unit.
// assumes one clock and a synchronous active-low reset; sees only the unit's ports.
`timescale 1ns/1ns
module cabx_exec_checker
   import cabx_pkg::*;
#(
   parameter int PCW = 16
)(
   input wire logic               CLK,
   input wire logic               RST_N,
   input wire logic               START,
   input wire cabx_pkg::cabx_op_t OP,
   input wire logic [11:0]        OFFSET,
   input wire logic [PCW-1:0]     PC,
   input wire logic [7:0]         FLAGS,
   input wire logic               BUSY,
   input wire logic               DONE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   logic           take;
   logic [PCW-1:0] off_ext;
   // accepted request and sign-extended offset
   assign take    = START && !BUSY;
   assign off_ext = {{(PCW-12){OFFSET[11]}}, OFFSET};

   a_alu_one_cycle : assert property (
      take && OP inside {[OP_ADD_REGS:OP_ADD_WITH_CARRY], [OP_SUB_REGS:OP_SUB_IMMEDIATE_WITH_CARRY],
      [OP_AND_REGS:OP_CLEAR_BITS_MASK], OP_TEST_ZERO_MINUS, [OP_COMPARE_REGS:OP_COMPARE_IMMEDIATE]} |=> DONE && !BUSY)
      else $error("single cycle op late");
   a_word_two_cycle : assert property (
      take && OP inside {OP_WORD_ADD_IMMEDIATE, OP_WORD_SUB_IMMEDIATE} |=> BUSY && !DONE ##1 DONE && !BUSY)
      else $error("word op not two cycles");
   a_call_three : assert property (
      take && OP inside {OP_RELATIVE_CALL, OP_POINTER_CALL} |=> BUSY [*2] ##1 (DONE && !BUSY))
      else $error("call not three cycles");
   a_return_four : assert property (
      take && OP inside {OP_SUB_RETURN, OP_INTERRUPT_RETURN} |=> BUSY [*3] ##1 (DONE && !BUSY))
      else $error("return not four cycles");
   a_rel_target : assert property (
      take && OP inside {OP_RELATIVE_JUMP, OP_RELATIVE_CALL} |=> PC == PCW'($past(PC) + $past(off_ext) + 1))
      else $error("relative target wrong");
   a_flow_flags_kept : assert property (
      take && OP inside {[OP_RELATIVE_JUMP:OP_SUB_RETURN], [OP_COMPARE_SKIP_EQUAL:OP_COMPARE_SKIP_EQUAL],
      [OP_SKIP_REG_BIT_CLEAR:OP_BRANCH_BITSTORE_CLEAR]} |=> FLAGS == $past(FLAGS))
      else $error("flow op changed flags");
   a_iret_sets_i : assert property (
      take && OP == OP_INTERRUPT_RETURN |=> FLAGS[FLAG_I])
      else $error("interrupt return left enable clear");
   a_vs_not_taken : assert property (
      take && OP == OP_BRANCH_OVERFLOW_SET && !FLAGS[FLAG_V] |=> DONE && PC == PCW'($past(PC) + 1))
      else $error("untaken overflow branch wrong");
   a_ge_taken : assert property (
      take && OP == OP_BRANCH_SIGNED_GE && !(FLAGS[FLAG_N] ^ FLAGS[FLAG_V])
      |=> (BUSY && PC == PCW'($past(PC) + $past(off_ext) + 1)) ##1 DONE)
      else $error("signed ge branch not taken");
   a_busy_holds : assert property (BUSY |=> $stable(PC) && $stable(FLAGS))
      else $error("state moved while busy");
endmodule // cabx_exec_checker

bind cabx_exec cabx_exec_checker #(.PCW(PCW)) i_chk (.CLK(CLK), .RST_N(RST_N), .START(START), .OP(OP),
   .OFFSET(OFFSET), .PC(PC), .FLAGS(FLAGS), .BUSY(BUSY), .DONE(DONE));

/* sim/testbench.sv */
// self-checking bench for the alu and branch execution unit.
// assumes cabx_pkg and cabx_exec are compiled first; drives all ports itself.
`timescale 1ns/1ns
module testbench;
   import cabx_pkg::*;
   logic        CLK, RST_N, START, SKIP_LONG, RF_WE, BUSY, DONE;
   cabx_op_t    OP, o, fo;
   logic [4:0]  RD, RR, RF_WADDR, RF_RADDR;
   logic [7:0]  K, IO_VALUE, RF_WDATA, RF_RDATA, FLAGS, va, vb, got, f;
   logic [2:0]  BIT_SEL;
   logic [11:0] OFFSET;
   logic [15:0] PC, p, e;
   logic        t;
   int          bad_count, checked, n;

   cabx_exec i_dut (.CLK(CLK), .RST_N(RST_N), .START(START), .OP(OP), .RD(RD), .RR(RR), .K(K),
      .BIT_SEL(BIT_SEL), .OFFSET(OFFSET), .IO_VALUE(IO_VALUE), .SKIP_LONG(SKIP_LONG), .RF_WE(RF_WE),
      .RF_WADDR(RF_WADDR), .RF_WDATA(RF_WDATA), .RF_RADDR(RF_RADDR), .RF_RDATA(RF_RDATA), .PC(PC),
      .FLAGS(FLAGS), .BUSY(BUSY), .DONE(DONE));

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // write a register pair on two edges, strobe held high between them
   task automatic wr(input logic [4:0] a, input logic [7:0] d0, d1);
      RF_WE = 1'b1;
      RF_WADDR = a;
      RF_WDATA = d0;
      @(posedge CLK) #1 RF_WADDR = a + 5'h01;
      RF_WDATA = d1;
      @(posedge CLK) #1 RF_WE = 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, output logic [7:0] v);
      RF_RADDR = a;
      @(posedge CLK) #1 v = RF_RDATA;
   endtask
   // issue one op and count cycles up to the done pulse
   task automatic go(input cabx_op_t op);
      START = 1'b1;
      OP = op;
      @(posedge CLK) #1 START = 1'b0;
      n = 1;
      while (DONE !== 1'b1 && n < 8)
      begin
         @(posedge CLK) #1 n++;
      end
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // expected values
   // ---------------------------------------------------------------
   function automatic logic [15:0] alu(input cabx_op_t op, input logic [7:0] a, b, fl);
      logic [8:0] r;
      logic       kz, cb, v;
      kz = op inside {OP_SUB_WITH_CARRY, OP_SUB_IMMEDIATE_WITH_CARRY, OP_COMPARE_WITH_CARRY};
      cb = fl[FLAG_C] & (kz | op == OP_ADD_WITH_CARRY);
      v = 1'b0;
      if (op == OP_TWOS_COMPLEMENT)
      begin
         b = a;
         a = 8'h00;
      end
      case (op)
         OP_AND_REGS, OP_AND_IMMEDIATE, OP_TEST_ZERO_MINUS: r = {1'b0, a & b};
         OP_CLEAR_BITS_MASK: r = {1'b0, a & ~b};
         OP_OR_REGS, OP_OR_IMMEDIATE, OP_SET_BITS_MASK: r = {1'b0, a | b};
         OP_EXCLUSIVE_OR_REGS: r = {1'b0, a ^ b};
         OP_INCREMENT, OP_DECREMENT:
         begin
            r = {1'b0, op == OP_INCREMENT ? a + 8'h01 : a - 8'h01};
            v = r[7:0] == (op == OP_INCREMENT ? 8'h80 : 8'h7f);
         end
         OP_CLEAR_REG: r = 9'h000;
         OP_SET_ALL_ONES: return {fl, 8'hff};
         OP_ONES_COMPLEMENT: r = {1'b1, ~a};
         OP_ADD_REGS, OP_ADD_WITH_CARRY:
         begin
            r = {1'b0, a} + {1'b0, b} + 9'(cb);
            v = (a[7] ~^ b[7]) & (a[7] ^ r[7]);
            fl[FLAG_H] = ({1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(cb)) > 5'h0f;
         end
         default:
         begin
            r = {1'b0, a} - {1'b0, b} - 9'(cb);
            v = (a[7] ^ b[7]) & (a[7] ^ r[7]);
            fl[FLAG_H] = {1'b0, a[3:0]} < {1'b0, b[3:0]} + 5'(cb);
         end
      endcase
      if (op inside {OP_ONES_COMPLEMENT, OP_TWOS_COMPLEMENT, [OP_ADD_REGS:OP_SUB_IMMEDIATE_WITH_CARRY],
         [OP_COMPARE_REGS:OP_COMPARE_IMMEDIATE]})
         fl[FLAG_C] = r[8];
      fl[FLAG_Z] = (r[7:0] == 8'h00) & (fl[FLAG_Z] | !kz);
      fl[FLAG_N] = r[7];
      fl[FLAG_V] = v;
      return {fl, r[7:0]};
   endfunction
   function automatic logic cond(input cabx_op_t op, input logic [7:0] fl, x, y, io, input logic [2:0] s);
      case (op)
         OP_BRANCH_FLAG_SET: return fl[s];
         OP_BRANCH_FLAG_CLEAR: return !fl[s];
         OP_BRANCH_SIGNED_GE: return !(fl[FLAG_N] ^ fl[FLAG_V]);
         OP_BRANCH_SIGNED_LT: return fl[FLAG_N] ^ fl[FLAG_V];
         OP_BRANCH_UNSIGNED_GE: return !fl[FLAG_C];
         OP_BRANCH_UNSIGNED_LT: return fl[FLAG_C];
         OP_BRANCH_HALFCARRY_SET: return fl[FLAG_H];
         OP_BRANCH_HALFCARRY_CLEAR: return !fl[FLAG_H];
         OP_BRANCH_IRQ_ENABLED: return fl[FLAG_I];
         OP_BRANCH_IRQ_DISABLED: return !fl[FLAG_I];
         OP_BRANCH_OVERFLOW_SET: return fl[FLAG_V];
         OP_BRANCH_OVERFLOW_CLEAR: return !fl[FLAG_V];
         OP_BRANCH_BITSTORE_SET: return fl[FLAG_T];
         OP_BRANCH_BITSTORE_CLEAR: return !fl[FLAG_T];
         OP_COMPARE_SKIP_EQUAL: return x == y;
         OP_SKIP_REG_BIT_CLEAR: return !y[s];
         OP_SKIP_REG_BIT_SET: return y[s];
         OP_SKIP_IO_BIT_CLEAR: return !io[s];
         default: return io[s];
      endcase
   endfunction

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   // word add and subtract on a register pair, corners first
   task automatic words();
      logic [15:0] w, r;
      logic [7:0]  lo, hi;
      for (int i = 0; i < 40; i++)
      begin
         w = (i == 0) ? 16'h7fff : (i == 1) ? 16'h0000 : 16'($urandom);
         K = (i < 2) ? 8'h01 : 8'($urandom);
         RD = {4'hc, 1'(i >> 1)};
         wr(5'h18, w[7:0], w[15:8]);
         f = FLAGS;
         r = i[0] ? w - K[5:0] : w + K[5:0];
         f[FLAG_C] = i[0] ? w < K[5:0] : r < w;
         f[FLAG_V] = i[0] ? w[15] & ~r[15] : ~w[15] & r[15];
         f[FLAG_Z] = r == 16'h0000;
         f[FLAG_N] = r[15];
         f[FLAG_S] = r[15] ^ f[FLAG_V];
         go(i[0] ? OP_WORD_SUB_IMMEDIATE : OP_WORD_ADD_IMMEDIATE);
         check(48'(n), 48'h2);
         check(48'(FLAGS), 48'(f));
         rd(5'h18, lo);
         rd(5'h19, hi);
         check(48'({hi, lo}), 48'(r));
      end
      $display("test word ops done");
   endtask
   // jumps, calls and returns through the stack
   task automatic flows();
      logic [15:0] z;
      z = 16'($urandom);
      wr(5'h1e, z[7:0], z[15:8]);
      p = PC;
      f = FLAGS;
      go(OP_POINTER_CALL);
      check(48'({16'(n), PC}), 48'({16'h0003, z}));
      go(OP_SUB_RETURN);
      check(48'({16'(n), PC}), 48'({16'h0004, p + 16'h0001}));
      go(OP_POINTER_JUMP);
      check({16'(n), PC, 16'(FLAGS)}, {16'h0002, z, 16'(f)});
      OFFSET = 12'h800;
      p = PC;
      go(OP_RELATIVE_CALL);
      check(48'({16'(n), PC}), 48'({16'h0003, p - 16'h07ff}));
      go(OP_INTERRUPT_RETURN);
      check({16'(n), PC, 15'h0000, FLAGS[FLAG_I]}, {16'h0004, p + 16'h0001, 16'h0001});
      OFFSET = 12'h7ff;
      p = PC;
      go(OP_RELATIVE_JUMP);
      check(48'({16'(n), PC}), 48'({16'h0002, p + 16'h0800}));
      $display("test jumps and calls done");
   endtask

   // clock and watchdog
   initial
   begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end
   initial
   begin
      repeat (30000) @(posedge CLK);
      bad_count++;
      results();
   end

   // main sequence: reset, word ops, then random alu op followed by a random flow op
   initial
   begin
      {START, SKIP_LONG, RF_WE, RST_N} = 4'h0;
      {RD, RR, RF_WADDR, RF_RADDR, K, IO_VALUE, RF_WDATA, BIT_SEL, OFFSET} = '0;
      OP = OP_ADD_REGS;
      void'($urandom(15));
      repeat (2) @(posedge CLK);
      #1 RST_N = 1'b1;
      rd(5'h00, got);
      check({8'h00, PC, 8'h00, FLAGS, got}, 48'h0);
      words();
      for (int i = 0; i < 300; i++)
      begin
         if (i == 150)
            flows();
         va = 8'($urandom);
         vb = 8'($urandom);
         wr(5'h10, va, vb);
         do o = cabx_op_t'($urandom_range(31));
         while (o inside {OP_WORD_ADD_IMMEDIATE, OP_WORD_SUB_IMMEDIATE, [OP_RELATIVE_JUMP:OP_COMPARE_SKIP_EQUAL],
            OP_TEST_ZERO_MINUS} && !(o == OP_TEST_ZERO_MINUS && i[0]));
         K = 8'($urandom);
         RD = 5'h10;
         RR = 5'h11;
         f = FLAGS;
         p = PC;
         t = o inside {OP_AND_IMMEDIATE, OP_OR_IMMEDIATE, OP_SUB_IMMEDIATE, OP_SUB_IMMEDIATE_WITH_CARRY,
            OP_COMPARE_IMMEDIATE, OP_SET_BITS_MASK, OP_CLEAR_BITS_MASK};
         e = alu(o, va, o == OP_TEST_ZERO_MINUS ? va : t ? K : vb, f);
         go(o);
         check({16'(n), PC, 16'(FLAGS)}, {16'h0001, p + 16'h0001, 16'(e[15:8])});
         rd(5'h10, got);
         check(48'(got), 48'(o inside {OP_TEST_ZERO_MINUS, [OP_COMPARE_REGS:OP_COMPARE_IMMEDIATE]} ? va : e[7:0]));
         fo = ($urandom_range(5) == 0) ? OP_COMPARE_SKIP_EQUAL : cabx_op_t'($urandom_range(49, 32));
         if (fo == OP_COMPARE_SKIP_EQUAL && $urandom_range(1) == 1)
         begin
            wr(5'h10, got, got);
            vb = got;
         end
         BIT_SEL = 3'($urandom);
         OFFSET = 12'($urandom);
         IO_VALUE = 8'($urandom);
         SKIP_LONG = 1'($urandom);
         f = FLAGS;
         p = PC;
         t = cond(fo, f, got, vb, IO_VALUE, BIT_SEL);
         go(fo);
         e = !t ? p + 16'h0001 : (fo < OP_BRANCH_FLAG_SET) ? p + 16'h0002 + 16'(SKIP_LONG) :
            p + {{4{OFFSET[11]}}, OFFSET} + 16'h0001;
         check({16'(n), PC, 16'(FLAGS)}, {t ? 16'h0002 : 16'h0001, e, 16'(f)});
      end
      $display("test random alu and flow done");
      results();
   end
endmodule // testbench
